// file: pkg/asq_pkg.sv
// Package with states and timing constants for the amplifier startup/protection sequencer
package asq_pkg;
    // System clock rate in Hz
    localparam int CLK_HZ = 100_000_000;
    // Documented durations in their own units
    localparam int RAMP_MS = 20;
    localparam int FAULT_HOLD_MS = 4;
    localparam int CLIP_PULSE_NS = 500;
    // Cycle counts derived from the clock rate
    localparam int RAMP_CYC = RAMP_MS * (CLK_HZ / 1000);
    localparam int FAULT_HOLD_CYC = FAULT_HOLD_MS * (CLK_HZ / 1000);
    localparam int CLIP_PULSE_CYC = (CLIP_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Default phase lengths not printed as times
    localparam int PRECHARGE_CYC = 1000;
    localparam int SHORT_STEP_CYC = 1000;
    localparam int FRAME_CYC = 256;
    localparam int OVL_MAX = 8;
    localparam int INJECT_EVERY = 4;
    // Half-bridge lanes and channel count
    localparam int NHB = 4;
    localparam int NCH = 2;
    // Sequencer states
    typedef enum logic [2:0] {
        ASQ_OFF, ASQ_WAIT_UV, ASQ_SHORT_GND, ASQ_SHORT_SUP, ASQ_PRECHARGE, ASQ_RAMP_UP, ASQ_RUN, ASQ_RAMP_DOWN
    } asq_state_t;
endpackage

// file: pkg/asq_if.sv
// Interface joining the amplifier sequencer and its controlling microcontroller
`timescale 1ns/1ps
interface asq_if;
    logic reset_n;
    logic fault_n;
    logic warn_clip_n;
    logic mute_o;
    logic mute_oe_n;
    logic soft_mute_node;
    // Open-drain mute line: low while driver enabled
    assign soft_mute_node = mute_oe_n ? 1'b1 : mute_o;
    modport dev (input reset_n, input soft_mute_node, output fault_n, output warn_clip_n);
    modport mcu (output reset_n, output mute_o, output mute_oe_n, input fault_n, input warn_clip_n);
endinterface

// file: rtl/asq_device.sv
// Power-state and protection sequencer of a two-channel switching amplifier
// Functional notes
// - Controller holds reset until power supply settles
// - Outputs hi-z and pulled down until supplies good
// - Fault low after reset release until analog good
// - Precharge then ramp up about 20 ms
// - Controller holds reset during power-down
// - Reset low ramps down, hi-z, low power
// - Weak pull-downs on while reset low
// - Fault forced high while reset low
// - Reset rising edge clears latched faults
// - Reset rises at least 4 ms after fault falls
// - Mute low ramps down, circuits stay powered
// - External mute driver must be open-drain
// - Fault: hi-z, fault low, most self-recover
// - Local errors shut A+B, C+D, or all
// - Bootstrap undervoltage shuts one half-bridge only
// - Overcurrent flips bridge until next frame
// - Persistent limiting latches channel off
// - Clipping injects pulses every fourth frame
// - Clipping flagged as 500 ns warning pulses
// - Imbalance counter at max shuts channel
// - Two-step short test after reset rises
// - Fault low during short test; reset restarts
`timescale 1ns/1ps
module asq_device
    import asq_pkg::*;
#(
    parameter int RAMP_CYCLES = RAMP_CYC,
    parameter int PRECHARGE_CYCLES = PRECHARGE_CYC,
    parameter int SHORT_CYCLES = SHORT_STEP_CYC,
    parameter int FRAME_CYCLES = FRAME_CYC,
    parameter int OVL_LIMIT = OVL_MAX
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controller link
    asq_if.dev link,
    // Supply monitors
    input wire logic gate_drive_supply_ok,
    input wire logic analog_supply_ok,
    input wire logic supply_fault,
    // Protection inputs
    input wire logic thermal_shutdown,
    input wire logic [NHB-1:0] local_error,
    input wire logic [NHB-1:0] boot_uv,
    input wire logic [NCH-1:0] overcurrent,
    input wire logic [NCH-1:0] limit_at_max,
    input wire logic [NCH-1:0] imbalance,
    input wire logic short_to_gnd,
    input wire logic short_to_sup,
    input wire logic clipping,
    input wire logic parallel_bridge_mode,
    // Power stage controls
    output logic [NHB-1:0] hb_enable,
    output logic [NHB-1:0] hb_pulldown,
    output logic [NCH-1:0] bridge_flip,
    output logic pulse_inject,
    output logic ramp_active,
    output logic low_power
);
    asq_state_t state, next_state;
    logic [31:0] cnt;
    logic [31:0] frame_cnt;
    logic [1:0] inj_cnt;
    logic reset_q;
    logic thermal_latch;
    logic [NCH-1:0] chan_latch;
    logic [3:0] ovl_cnt [NCH];
    logic fault_q, warn_q;
    logic [7:0] clip_cnt;
    logic clip_q;

    // Channel masks from local errors
    function automatic logic [NCH-1:0] err_chan(input logic [NHB-1:0] e, input logic par);
        logic [NCH-1:0] c;
        c = {|e[3:2], |e[1:0]};
        err_chan = par ? {NCH{|e}} : c;
    endfunction

    wire reset_rise = link.reset_n && !reset_q;
    wire supplies_ok = gate_drive_supply_ok && analog_supply_ok;
    wire [NCH-1:0] local_off = err_chan(local_error, parallel_bridge_mode);
    wire global_off = supply_fault || thermal_latch || !supplies_ok;
    wire [NCH-1:0] chan_off = local_off | chan_latch;
    wire phase_done = (cnt == 32'd0);
    wire frame_start = (frame_cnt == 32'd0);
    wire muted = !link.soft_mute_node;
    wire running = (state == ASQ_RUN);
    wire [NHB-1:0] hb_on = {{2{chan_off[1]}}, {2{chan_off[0]}}};
    wire [NHB-1:0] next_hb = (running && !global_off) ? (~hb_on & ~boot_uv) : '0;
    wire any_fault = global_off || (|chan_off) || state == ASQ_WAIT_UV
        || state == ASQ_SHORT_GND || state == ASQ_SHORT_SUP;
    wire next_fault_n = !link.reset_n ? 1'b1 : !any_fault;

    // Sequencer transitions
    always_comb begin
        next_state = state;
        unique case (state)
            ASQ_OFF: if (reset_rise) next_state = ASQ_WAIT_UV;
            ASQ_WAIT_UV: if (supplies_ok) next_state = ASQ_SHORT_GND;
            ASQ_SHORT_GND: if (phase_done && !short_to_gnd) next_state = ASQ_SHORT_SUP;
            ASQ_SHORT_SUP: if (phase_done && !short_to_sup) next_state = ASQ_PRECHARGE;
            ASQ_PRECHARGE: if (phase_done) next_state = ASQ_RAMP_UP;
            ASQ_RAMP_UP: if (phase_done) next_state = ASQ_RUN;
            ASQ_RUN: if (!link.reset_n || muted) next_state = ASQ_RAMP_DOWN;
            ASQ_RAMP_DOWN: begin
                if (phase_done) next_state = link.reset_n ? (muted ? ASQ_RAMP_DOWN : ASQ_RAMP_UP) : ASQ_OFF;
            end
        endcase
        if (!link.reset_n && state != ASQ_RUN && state != ASQ_RAMP_DOWN) next_state = ASQ_OFF;
        if (reset_rise) next_state = ASQ_WAIT_UV; // Rise during ramp-down must not skip the short test
    end

    // Phase counter reload on every state change
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ASQ_OFF;
            cnt <= 32'd0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                unique case (next_state)
                    ASQ_SHORT_GND, ASQ_SHORT_SUP: cnt <= 32'(SHORT_CYCLES - 1);
                    ASQ_PRECHARGE: cnt <= 32'(PRECHARGE_CYCLES - 1);
                    ASQ_RAMP_UP, ASQ_RAMP_DOWN: cnt <= 32'(RAMP_CYCLES - 1);
                    default: cnt <= 32'd0;
                endcase
            end else if (cnt != 32'd0) begin
                cnt <= cnt - 32'd1;
            end
        end
    end

    // Latched faults, cleared by reset rising edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_q <= 1'b0;
            thermal_latch <= 1'b0;
            chan_latch <= '0;
            ovl_cnt <= '{default: 4'h0};
        end else begin
            reset_q <= link.reset_n;
            if (reset_rise) begin
                thermal_latch <= 1'b0;
                chan_latch <= '0;
                ovl_cnt <= '{default: 4'h0};
            end else begin
                if (thermal_shutdown && running) thermal_latch <= 1'b1;
                for (int c = 0; c < NCH; c++) begin
                    if (running && limit_at_max[c]) chan_latch[c] <= 1'b1;
                    if (running && imbalance[c] && ovl_cnt[c] != 4'(OVL_LIMIT)) ovl_cnt[c] <= ovl_cnt[c] + 4'h1;
                    if (ovl_cnt[c] == 4'(OVL_LIMIT)) chan_latch[c] <= 1'b1;
                end
                if (parallel_bridge_mode && |chan_latch) chan_latch <= '1;
            end
        end
    end

    // Frame timing, flips and pulse injection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_cnt <= 32'd0;
            inj_cnt <= 2'h0;
            bridge_flip <= '0;
            pulse_inject <= 1'b0;
        end else begin
            frame_cnt <= frame_start ? 32'(FRAME_CYCLES - 1) : frame_cnt - 32'd1;
            if (frame_start) inj_cnt <= inj_cnt + 2'h1;
            bridge_flip <= (frame_start ? '0 : bridge_flip) | (overcurrent & {NCH{running}}); // New event wins
            pulse_inject <= running && frame_start && inj_cnt == 2'(INJECT_EVERY - 1)
                && (clipping || |overcurrent);
        end
    end

    // Clip warning pulse stretch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clip_q <= 1'b0;
            clip_cnt <= 8'h0;
            warn_q <= 1'b1;
        end else begin
            clip_q <= clipping;
            if (clipping && !clip_q && running) clip_cnt <= 8'(CLIP_PULSE_CYC);
            else if (clip_cnt != 8'h0) clip_cnt <= clip_cnt - 8'h1;
            warn_q <= !(clip_cnt != 8'h0);
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_q <= 1'b1;
            hb_enable <= '0;
            hb_pulldown <= '1;
            ramp_active <= 1'b0;
            low_power <= 1'b1;
        end else begin
            fault_q <= next_fault_n;
            hb_enable <= next_hb;
            hb_pulldown <= (!link.reset_n || state == ASQ_WAIT_UV) ? '1 : '0;
            ramp_active <= (state == ASQ_RAMP_UP || state == ASQ_RAMP_DOWN);
            low_power <= (state == ASQ_OFF);
        end
    end

    assign link.fault_n = fault_q;
    assign link.warn_clip_n = warn_q;
endmodule

// file: rtl/asq_mcu.sv
// Controller end: drives reset and open-drain mute, honours fault spacing
`timescale 1ns/1ps
module asq_mcu
    import asq_pkg::*;
#(
    parameter int HOLD_CYCLES = FAULT_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // User side
    input wire logic run_req,
    input wire logic mute_req,
    input wire logic supply_stable,
    output logic fault_seen,
    output logic clip_seen,
    // Device link
    asq_if.mcu link
);
    logic reset_q, mute_oe_q, fault_d, armed;
    logic [31:0] hold;

    wire fault_fall = fault_d && !link.fault_n;
    wire may_release = (hold == 32'd0) && supply_stable;
    // Startup faults are ignored; a fault still present after the hold is treated as latched
    wire clear_latch = reset_q && armed && !link.fault_n && !fault_fall && (hold == 32'd0);

    // Reset and mute control
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_q <= 1'b0;
            mute_oe_q <= 1'b1;
            fault_d <= 1'b1;
            armed <= 1'b0;
            hold <= 32'd0;
            fault_seen <= 1'b0;
            clip_seen <= 1'b0;
        end else begin
            fault_d <= link.fault_n;
            if (fault_fall) hold <= 32'(HOLD_CYCLES);
            else if (hold != 32'd0) hold <= hold - 32'd1;
            if (!reset_q) armed <= 1'b0;
            else if (!fault_d && link.fault_n) armed <= 1'b1; // Startup finished
            if (!run_req || !supply_stable) reset_q <= 1'b0;
            else if (clear_latch) reset_q <= 1'b0;
            else if (!reset_q && may_release && link.fault_n) reset_q <= 1'b1;
            mute_oe_q <= !mute_req;
            fault_seen <= !link.fault_n;
            clip_seen <= !link.warn_clip_n;
        end
    end

    assign link.reset_n = reset_q;
    assign link.mute_o = 1'b0;
    assign link.mute_oe_n = mute_oe_q;
endmodule

// file: verification/asq_props.sv
// Concurrent checks on the link between sequencer and controller
`timescale 1ns/1ps
module asq_props
    import asq_pkg::*;
#(
    parameter int HOLD_CYCLES = FAULT_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link signals
    input wire logic reset_n,
    input wire logic fault_n,
    input wire logic warn_clip_n,
    input wire logic mute_o,
    input wire logic mute_oe_n,
    input wire logic soft_mute_node
);
    int since_fall;
    // Cycles since the fault line last fell, saturating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            since_fall <= 1 << 30;
        end else if ($fell(fault_n)) begin
            since_fall <= 1;
        end else if (since_fall < (1 << 30)) begin
            since_fall <= since_fall + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Fault line and startup
    chk_fault_forced_high: assert property (!reset_n |=> fault_n)
        else $error("fault line low while reset held");
    chk_fault_on_start: assert property (disable iff (!rstn || !reset_n) $rose(reset_n) |-> ##[1:4] (!fault_n [*8]))
        else $error("fault line not held low after reset release");
    chk_start_fault_ends: assert property (disable iff (!rstn || !reset_n) $rose(reset_n) |-> ##[1:400] fault_n)
        else $error("fault line never released after startup");
    chk_fault_spacing: assert property ($rose(reset_n) |-> since_fall >= HOLD_CYCLES)
        else $error("reset raised too soon after fault");
    // Mute line, clip flag and fault line on reset fall
    chk_mute_never_high: assert property (mute_o == 1'b0)
        else $error("mute line driven high");
    chk_mute_node_low: assert property (!mute_oe_n |-> !soft_mute_node)
        else $error("mute node not pulled low");
    chk_clip_pulse_width: assert property ($fell(warn_clip_n) |-> (!warn_clip_n throughout ##49 1'b1) ##1 warn_clip_n)
        else $error("clip pulse width wrong");
    chk_reset_fault_hold: assert property ($fell(reset_n) |=> fault_n [*2])
        else $error("fault line not forced high on reset");
    // Main scenarios
    cov_start: cover property ($rose(reset_n));
    cov_clip: cover property ($fell(warn_clip_n));
    cov_mute: cover property ($fell(mute_oe_n));
endmodule

// file: verification/test_amp_startup_mute_protection_seq.sv
// Self-checking bench joining sequencer and controller over the link
`timescale 1ns/1ps
module test_amp_startup_mute_protection_seq;
    import asq_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, gd_ok = 1'b1, an_ok = 1'b0, sup_flt = 1'b0, therm = 1'b0, pbm = 1'b0;
    logic gnd_sh = 1'b0, sup_sh = 1'b0, clip = 1'b0, run = 1'b0, mute = 1'b0, stable = 1'b0;
    logic [3:0] lerr = 4'h0, buv = 4'h0, hb_en, hb_pd;
    logic [1:0] oc = 2'h0, lim = 2'h0, imb = 2'h0, flip;
    logic inj, ramp, lowp, f_seen, c_seen;
    int miscompares = 0, check_count = 0, cyc = 0, n, k;
    asq_if link_bus ();
    asq_device #(.RAMP_CYCLES(50), .PRECHARGE_CYCLES(10), .SHORT_CYCLES(10), .FRAME_CYCLES(8), .OVL_LIMIT(8)) asq_device_i (
        .clk(clk), .rstn(rstn), .link(link_bus), .gate_drive_supply_ok(gd_ok), .analog_supply_ok(an_ok),
        .supply_fault(sup_flt), .thermal_shutdown(therm), .local_error(lerr), .boot_uv(buv), .overcurrent(oc),
        .limit_at_max(lim), .imbalance(imb), .short_to_gnd(gnd_sh), .short_to_sup(sup_sh), .clipping(clip),
        .parallel_bridge_mode(pbm), .hb_enable(hb_en), .hb_pulldown(hb_pd), .bridge_flip(flip),
        .pulse_inject(inj), .ramp_active(ramp), .low_power(lowp));
    asq_mcu #(.HOLD_CYCLES(20)) asq_mcu_i (.clk(clk), .rstn(rstn), .run_req(run), .mute_req(mute),
        .supply_stable(stable), .fault_seen(f_seen), .clip_seen(c_seen), .link(link_bus));
    asq_props #(.HOLD_CYCLES(20)) asq_props_i (.clk(clk), .rstn(rstn), .reset_n(link_bus.reset_n),
        .fault_n(link_bus.fault_n), .warn_clip_n(link_bus.warn_clip_n), .mute_o(link_bus.mute_o),
        .mute_oe_n(link_bus.mute_oe_n), .soft_mute_node(link_bus.soft_mute_node));
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded waits on enables and the reset line
    task automatic wait_hb(input logic [3:0] exp);
        for (n = 0; n < 600 && hb_en !== exp; n++) @(negedge clk);
        cmp(hb_en, exp);
    endtask
    task automatic wait_rst(input logic lvl);
        for (n = 0; n < 600 && link_bus.reset_n !== lvl; n++) @(negedge clk);
        cmp(4'(link_bus.reset_n), 4'(lvl));
    endtask
    // Test sequence, inputs change on falling edges
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        cmp(4'(link_bus.fault_n), 4'h1);
        cmp(hb_pd, 4'hf);
        cmp(4'(lowp) | hb_en, 4'h1);
        $display("test reset done");
        stable = 1'b1;
        run = 1'b1;
        gnd_sh = 1'b1;
        wait_rst(1'b1);
        repeat (8) @(negedge clk);
        cmp(4'(link_bus.fault_n) | hb_en, 4'h0);
        an_ok = 1'b1;
        repeat (30) @(negedge clk);
        gnd_sh = 1'b0;
        sup_sh = 1'b1;
        repeat (30) @(negedge clk);
        cmp(hb_en | 4'(link_bus.fault_n), 4'h0);
        sup_sh = 1'b0;
        repeat (15) @(negedge clk);
        cmp(4'(ramp), 4'h1);
        wait_hb(4'hf);
        $display("test startup done");
        // Local errors in both bridge modes
        for (int m = 0; m < 8; m++) begin
            pbm = m[2];
            lerr = 4'h1 << m[1:0];
            repeat (4) @(negedge clk);
            cmp(hb_en, m[2] ? 4'h0 : (m[1] ? 4'h3 : 4'hc));
            lerr = 4'h0;
            wait_hb(4'hf);
        end
        pbm = 1'b0;
        for (int b = 0; b < 4; b++) begin
            buv = 4'h1 << b;
            repeat (4) @(negedge clk);
            cmp(hb_en, ~buv);
            cmp(4'(link_bus.fault_n), 4'h1);
            buv = 4'h0;
            wait_hb(4'hf);
        end
        // Current limiting, pulse injection, clipping
        oc = 2'h3;
        repeat (3) @(negedge clk);
        cmp(4'(flip), 4'h3);
        k = 0;
        repeat (64) begin
            @(negedge clk);
            k += inj;
        end
        cmp(4'(k), 4'h2);
        oc = 2'h0;
        repeat (10) @(negedge clk);
        cmp(4'(flip), 4'h0);
        clip = 1'b1;
        for (n = 0; n < 20 && link_bus.warn_clip_n !== 1'b0; n++) @(negedge clk);
        for (k = 0; k < 99 && link_bus.warn_clip_n === 1'b0; k++) @(negedge clk);
        cmp(4'(k == CLIP_PULSE_CYC), 4'h1);
        cmp(4'(c_seen), 4'h1);
        clip = 1'b0;
        $display("test limiting done");
        // Soft mute, overload latch, imbalance shutdown
        mute = 1'b1;
        repeat (3) @(negedge clk);
        cmp(4'(link_bus.soft_mute_node), 4'h0);
        wait_hb(4'h0);
        cmp(4'(lowp), 4'h0);
        mute = 1'b0;
        wait_hb(4'hf);
        lim = 2'h2;
        repeat (4) @(negedge clk);
        lim = 2'h0;
        repeat (10) @(negedge clk);
        cmp(hb_en, 4'h3);
        wait_rst(1'b0);
        wait_rst(1'b1);
        wait_hb(4'hf);
        imb = 2'h1;
        wait_hb(4'hc);
        imb = 2'h0;
        wait_rst(1'b0);
        wait_rst(1'b1);
        wait_hb(4'hf);
        // Self-clearing supply faults, then latched thermal shutdown
        sup_flt = 1'b1;
        repeat (3) @(negedge clk);
        cmp(hb_en | 4'(link_bus.fault_n) | 4'(!f_seen), 4'h0);
        sup_flt = 1'b0;
        gd_ok = 1'b0;
        repeat (3) @(negedge clk);
        cmp(hb_en | 4'(link_bus.fault_n), 4'h0);
        gd_ok = 1'b1;
        wait_hb(4'hf);
        cmp(4'(link_bus.reset_n), 4'h1);
        therm = 1'b1;
        repeat (2) @(negedge clk);
        therm = 1'b0;
        repeat (10) @(negedge clk);
        cmp(hb_en | 4'(link_bus.fault_n), 4'h0);
        wait_rst(1'b0);
        wait_rst(1'b1);
        wait_hb(4'hf);
        $display("test faults done");
        // Controlled power-down
        run = 1'b0;
        wait_rst(1'b0);
        repeat (3) @(negedge clk);
        cmp(4'(ramp), 4'h1);
        for (n = 0; n < 600 && lowp !== 1'b1; n++) @(negedge clk);
        cmp({hb_pd[2:0], lowp} | hb_en, 4'hf);
        $display("test shutdown done");
        stop_test();
    end
endmodule
